// >>> common/sup_regs.svh
// Constants of the supervisor control logic: timing, register map, event bits.
// Assumes a 20 MHz system clock; included by bare name.
`ifndef SUP_REGS_SVH
`define SUP_REGS_SVH

`define SUP_CLK_NS 50
`define SUP_POR_MS 50
`define SUP_SHORT_MS 100
`define SUP_LONG_MS 1600
`define SUP_MS_TO_CYC(ms) 32'((64'd1000000 * (ms)) / `SUP_CLK_NS)

`define SUP_EXT_NORMAL 32'd1024
`define SUP_EXT_FIRST 32'd4096
`define SUP_EXT_RESET 32'd512

`define SUP_ADDR_STATUS 4'h0
`define SUP_ADDR_MASK 4'h4
`define SUP_ADDR_LIVE 4'h8

`define SUP_EV_WARN 0
`define SUP_EV_DOG 1
`define SUP_EV_LOW 2
`define SUP_EV_BATT 3

`define SUP_RST_STATUS 4'h0
`define SUP_RST_MASK 4'h0
`define SUP_RST_RDATA 8'h00

`endif

// >>> common/sup_pkg.sv
// Types shared by the supervisor control logic.
// Assumes nothing beyond a SystemVerilog compiler.
package sup_pkg;

	typedef enum logic [2:0] {
		ST_HOLD = 3'b001,
		ST_STRETCH = 3'b010,
		ST_RUN = 3'b100
	} sup_state_t;

	typedef struct packed {
		logic on_battery;
		logic supply_low;
		logic warn_low;
	} afe_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		sup_state_t st;
		logic ext_mode;
		logic first;
		logic dog_n;
		logic rst_n;
		logic rst_hi;
		logic low_n;
		logic warn_n;
		logic ce_n;
		logic batt;
		logic sl_prev;
		logic [3:0] status;
		logic [3:0] mask;
		logic [7:0] rdata;
	} core_t;

	typedef struct packed {
		logic [31:0] left;
	} timer_t;

	typedef struct packed {
		logic [1:0] prev;
		logic primed;
	} edge_t;

endpackage : sup_pkg

// >>> design/edge_watch.sv
// Transition detector for the kick pin and the external timebase pin.
// Assumes both inputs are already synchronous to clock.
`timescale 1ns/1ns
`default_nettype none
module edge_watch (
	input wire logic clock, // System clock
	input wire logic clk_en, // Freezes state while low
	input wire logic sys_rst, // Synchronous reset
	input wire logic [1:0] level, // Watched levels
	output logic [1:0] toggled, // Any transition this cycle
	output logic [1:0] rose // Rising transition this cycle
);
	import sup_pkg::*;

	edge_t s, n;

	// No edge is reported until a first sample is held
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_bit
			assign toggled[i] = s.primed & (level[i] ^ s.prev[i]);
			assign rose[i] = s.primed & level[i] & ~s.prev[i];
		end
	endgenerate

	always_comb begin
		n = s;
		n.prev = level;
		n.primed = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s <= '0;
		end else if (clk_en) begin
			s <= n;
		end
	end
endmodule : edge_watch
`default_nettype wire

// >>> design/period_timer.sv
// Down counter shared by the reset stretch and the watchdog period.
// Assumes the caller reloads it before relying on done.
`timescale 1ns/1ns
`default_nettype none
module period_timer (
	input wire logic clock, // System clock
	input wire logic clk_en, // Freezes state while low
	input wire logic sys_rst, // Synchronous reset
	input wire logic load, // Load a new period
	input wire logic [31:0] load_val, // Period in steps
	input wire logic step, // Count one step
	output logic done, // Period used up
	output logic [31:0] left // Steps remaining
);
	import sup_pkg::*;

	timer_t s, n;

	assign done = (s.left == 32'h0);
	assign left = s.left;

	always_comb begin
		n = s;
		if (load) begin
			n.left = load_val;
		end else if (step && !done) begin
			n.left = s.left - 32'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s <= '0;
		end else if (clk_en) begin
			s <= n;
		end
	end
endmodule : period_timer
`default_nettype wire

// >>> design/supervisor_core.sv
// Supervisor control logic: reset stretch, watchdog, warning and backup states.
// Assumes comparator results and pin levels arrive synchronous to clock.
//
// Function
// - Warning output goes low while the warning comparator reports below reference.
// - In backup mode reset_n is low, reset high and the low-line output low.
// - In backup mode watchdog status, gated enable and battery output are high, warning low.
// - In backup mode kick and timebase pins have no effect.
// - In backup mode the incoming chip enable is ignored and the gated enable stays high.
// - In backup mode the warning comparator has no effect on the warning output.
// - A floating kick input disables the watchdog entirely.
// - A low timebase select takes the watchdog period from the external oscillator.
// - With the external oscillator the period scales with its rate, as counted cycles.
// - A high timebase select uses the internal base, the timebase input picking the period.
// - With the internal base, reset stays asserted for 50 ms after the low-line input recovers.
// - A watchdog timeout drives the status low until the next kick transition or until low-line or backup mode.
// - Internal base gives 100 ms on a low input, else 1.6 s; the first period is 1.6 s.
// - While low-line is active the gated chip enable is forced high.
`timescale 1ns/1ns
`default_nettype none
`include "sup_regs.svh"
module supervisor_core #(
	parameter logic [31:0] POR_CYC = `SUP_MS_TO_CYC(`SUP_POR_MS), // Reset stretch
	parameter logic [31:0] SHORT_CYC = `SUP_MS_TO_CYC(`SUP_SHORT_MS), // Short period
	parameter logic [31:0] LONG_CYC = `SUP_MS_TO_CYC(`SUP_LONG_MS) // Long period
) (
	input wire logic clock, // 20 MHz system clock
	input wire logic clk_en, // Freezes all state while low
	input wire logic sys_rst, // Synchronous reset, active high
	input wire sup_pkg::afe_t afe, // Comparator and backup flags
	input wire logic dog_kick_in, // Watchdog kick level
	input wire logic dog_kick_float, // Kick pin seen undriven
	input wire logic timebase_select, // High: internal base
	input wire logic timebase_input, // Period pick or external oscillator
	input wire logic chip_en_in_n, // Incoming chip enable
	input wire sup_pkg::reg_req_t bus, // Register request
	output logic [7:0] rdata, // Read data, cycle after read
	output logic irq, // Unmasked event pending
	output logic reset_out_n, // Reset, active low
	output logic reset_out, // Reset, active high
	output logic low_line_out_n, // Low-line status
	output logic dog_expired_out_n, // Watchdog status
	output logic power_warn_out_n, // Power-fail warning
	output logic chip_en_out_n, // Gated chip enable
	output logic on_battery_out // Backup mode indication
);
	import sup_pkg::*;

	core_t s, n;

	logic [1:0] tog;
	logic [1:0] rise;
	logic t_load;
	logic [31:0] t_val;
	logic t_step;
	logic t_done;
	logic [31:0] t_left;
	logic in_down;
	logic ext_now;
	logic dog_bite;
	logic [3:0] evt;

	// Bit 0 is the kick pin, bit 1 the external oscillator
	edge_watch u_edges (
		.clock(clock),
		.clk_en(clk_en),
		.sys_rst(sys_rst),
		.level({timebase_input, dog_kick_in}),
		.toggled(tog),
		.rose(rise)
	);

	period_timer u_timer (
		.clock(clock),
		.clk_en(clk_en),
		.sys_rst(sys_rst),
		.load(t_load),
		.load_val(t_val),
		.step(t_step),
		.done(t_done),
		.left(t_left)
	);

	function automatic logic [31:0] first_val(input logic ext);
		first_val = ext ? `SUP_EXT_FIRST : LONG_CYC;
	endfunction : first_val

	function automatic logic [31:0] normal_val(input logic ext, input logic pick);
		if (ext) begin
			normal_val = `SUP_EXT_NORMAL;
		end else begin
			normal_val = pick ? LONG_CYC : SHORT_CYC;
		end
	endfunction : normal_val

	function automatic logic [31:0] stretch_val(input logic ext);
		stretch_val = ext ? `SUP_EXT_RESET : POR_CYC;
	endfunction : stretch_val

	assign in_down = afe.on_battery | afe.supply_low;
	assign ext_now = ~timebase_select;
	// One rising oscillator edge is one step; the capacitor sets its rate
	assign t_step = s.ext_mode ? rise[1] : 1'b1;

	assign rdata = s.rdata;
	assign irq = |(s.status & s.mask);
	assign reset_out_n = s.rst_n;
	assign reset_out = s.rst_hi;
	assign low_line_out_n = s.low_n;
	assign dog_expired_out_n = s.dog_n;
	assign power_warn_out_n = s.warn_n;
	assign chip_en_out_n = s.ce_n;
	assign on_battery_out = s.batt;

	always_comb begin
		n = s;
		t_load = 1'b0;
		t_val = 32'h0;
		dog_bite = 1'b0;
		evt = 4'h0;

		// Backup and low-line park the sequencer, so timebase pins are unused
		unique case (s.st)
			ST_HOLD: begin
				if (!in_down) begin
					n.st = ST_STRETCH;
					t_load = 1'b1;
					t_val = stretch_val(ext_now);
					n.ext_mode = ext_now;
				end
			end
			ST_STRETCH: begin
				if (in_down) begin
					n.st = ST_HOLD;
				end else if (t_done) begin
					n.st = ST_RUN;
					n.first = 1'b1;
					t_load = 1'b1;
					t_val = first_val(ext_now);
					n.ext_mode = ext_now;
				end
			end
			ST_RUN: begin
				if (in_down) begin
					n.st = ST_HOLD;
				end else if (dog_kick_float) begin
					// Reloading every cycle keeps the period from ever running out
					t_load = 1'b1;
					t_val = s.first ? first_val(ext_now) : normal_val(ext_now, timebase_input);
					n.ext_mode = ext_now;
				end else if (tog[0]) begin
					n.first = 1'b0;
					t_load = 1'b1;
					t_val = normal_val(ext_now, timebase_input);
					n.ext_mode = ext_now;
				end else if (t_done) begin
					dog_bite = 1'b1;
					n.st = ST_STRETCH;
					t_load = 1'b1;
					t_val = stretch_val(ext_now);
					n.ext_mode = ext_now;
				end
			end
		endcase

		// Status flag: low on a bite, high on a kick or low-line
		if (in_down) begin
			n.dog_n = 1'b1;
		end else if (dog_bite) begin
			n.dog_n = 1'b0;
		end else if (tog[0]) begin
			n.dog_n = 1'b1;
		end

		n.rst_n = (n.st == ST_RUN);
		n.rst_hi = (n.st != ST_RUN);
		n.low_n = ~in_down;
		// Comparator is dead in backup, so the warning is forced low
		n.warn_n = afe.on_battery ? 1'b0 : ~afe.warn_low;
		// Registered to keep outputs glitch free; costs one clock of latency
		n.ce_n = in_down ? 1'b1 : chip_en_in_n;
		n.batt = afe.on_battery;
		n.sl_prev = afe.supply_low;

		evt[`SUP_EV_WARN] = s.warn_n & ~n.warn_n & ~afe.on_battery;
		evt[`SUP_EV_DOG] = dog_bite;
		evt[`SUP_EV_LOW] = afe.supply_low & ~s.sl_prev;
		evt[`SUP_EV_BATT] = afe.on_battery & ~s.batt;

		// Set wins over a write-one clear in the same cycle
		n.status = s.status | evt;
		if (bus.wr && bus.addr == `SUP_ADDR_STATUS) begin
			n.status = (s.status & ~bus.wdata[3:0]) | evt;
		end
		if (bus.wr && bus.addr == `SUP_ADDR_MASK) begin
			n.mask = bus.wdata[3:0];
		end

		n.rdata = `SUP_RST_RDATA;
		if (bus.rd) begin
			unique case (bus.addr)
				`SUP_ADDR_STATUS: n.rdata = {4'h0, s.status};
				`SUP_ADDR_MASK: n.rdata = {4'h0, s.mask};
				`SUP_ADDR_LIVE: n.rdata = {s.st, s.first, s.ext_mode, s.dog_n, s.warn_n, s.rst_n};
				default: n.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s <= '0;
			s.st <= ST_HOLD;
			s.dog_n <= 1'b1;
			s.rst_hi <= 1'b1;
			s.warn_n <= 1'b1;
			s.ce_n <= 1'b1;
			s.status <= `SUP_RST_STATUS;
			s.mask <= `SUP_RST_MASK;
		end else if (clk_en) begin
			s <= n;
		end
	end

	chk_warn_follow: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && !afe.on_battery) |=> (power_warn_out_n == !$past(afe.warn_low)))
		else $error("warning output does not follow comparator");

	chk_batt_reset: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && afe.on_battery) |=> (!reset_out_n && reset_out && !low_line_out_n))
		else $error("reset outputs wrong in backup mode");

	chk_batt_levels: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && afe.on_battery)
		|=> (dog_expired_out_n && chip_en_out_n && on_battery_out && !power_warn_out_n))
		else $error("status outputs wrong in backup mode");

	chk_batt_ignore: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && afe.on_battery) [*2] |-> (s.st == ST_HOLD && !dog_bite && !t_load))
		else $error("pins acted on in backup mode");

	chk_batt_ce: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && afe.on_battery && !chip_en_in_n) |=> chip_en_out_n)
		else $error("chip enable passed in backup mode");

	chk_batt_pfi: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && afe.on_battery && !afe.warn_low) |=> !power_warn_out_n)
		else $error("comparator reached warning in backup mode");

	chk_float_quiet: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && dog_kick_float && !in_down && s.st == ST_RUN)
		|=> (s.st == ST_RUN && reset_out_n))
		else $error("watchdog fired while kick floats");

	chk_ext_select: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && t_load && !timebase_select) |=> s.ext_mode)
		else $error("external base not selected");

	chk_ext_scale: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && s.st == ST_RUN && !in_down && !dog_kick_float && tog[0] && !timebase_select)
		|=> (t_left == `SUP_EXT_NORMAL))
		else $error("external period count wrong");

	chk_int_short: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && s.st == ST_RUN && !in_down && !dog_kick_float && tog[0]
			&& timebase_select && !timebase_input)
		|=> (t_left == SHORT_CYC))
		else $error("internal short period wrong");

	chk_por_hold: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && s.st == ST_HOLD && !in_down && timebase_select)
		|=> (s.st == ST_STRETCH && t_left == POR_CYC && !reset_out_n))
		else $error("power-on reset stretch wrong");

	chk_dog_status: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && dog_bite) |=> (!dog_expired_out_n && !reset_out_n))
		else $error("timeout not shown on watchdog status");

	chk_first_long: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && s.st == ST_STRETCH && t_done && !in_down && timebase_select)
		|=> (t_left == LONG_CYC && s.first && reset_out_n))
		else $error("first period after reset not long");

	chk_lowline_ce: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && afe.supply_low) |=> chip_en_out_n)
		else $error("chip enable not gated on low line");

	chk_lowline_rst: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && afe.supply_low) |=> (!reset_out_n && reset_out && !low_line_out_n))
		else $error("reset released during low line");

	chk_lowline_dog: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && afe.supply_low) |=> dog_expired_out_n)
		else $error("watchdog status low during low line");

	chk_kick_clear: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && !in_down && tog[0]) |=> dog_expired_out_n)
		else $error("kick did not clear watchdog status");

	chk_dog_hold: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && !in_down && !tog[0] && !dog_expired_out_n) |=> !dog_expired_out_n)
		else $error("watchdog status cleared without kick");

	chk_dog_event: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && dog_bite) |=> s.status[`SUP_EV_DOG])
		else $error("timeout event not latched");

	chk_ce_follow: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && !in_down) |=> (chip_en_out_n == $past(chip_en_in_n)))
		else $error("chip enable not passed through");

	chk_float_armed: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && dog_kick_float && !in_down && s.st == ST_RUN) |=> !t_done)
		else $error("watchdog period ran out while kick floats");

	// Idle zero keeps a stale word from being taken as a second answer
	chk_rdata_idle: assert property (
		@(posedge clock) disable iff (sys_rst)
		(clk_en && !bus.rd) |=> (rdata == `SUP_RST_RDATA))
		else $error("read data not idle");

	// A low enable must leave every flop of the core state untouched
	chk_freeze_hold: assert property (
		@(posedge clock) disable iff (sys_rst)
		!clk_en |=> $stable(s))
		else $error("state moved while clock enable low");

endmodule : supervisor_core
`default_nettype wire

// >>> test/host_model.sv
// Host processor model: kicks the watchdog and takes the warning interrupt.
// Assumes mode and gap are driven from the bench clock domain.
`timescale 1ns/1ns
`default_nettype none
module host_model (
	input wire logic clock, // System clock
	input wire logic [1:0] mode, // 0 idle, 1 kick, 2 release pin
	input wire logic [7:0] gap, // Cycles between kicks
	input wire logic power_warn_out_n, // Warning interrupt
	output logic dog_kick_in, // Kick level
	output logic dog_kick_float, // Pin released
	output int warn_irqs // Interrupts taken
);
	logic [7:0] cnt = 8'h00;
	logic warn_q = 1'b1;
	logic kick_q = 1'b0;
	logic float_q = 1'b0;
	int irq_cnt = 0;
	assign dog_kick_in = kick_q;
	assign dog_kick_float = float_q;
	assign warn_irqs = irq_cnt;
	always @(posedge clock) begin
		warn_q <= power_warn_out_n;
		if (warn_q && !power_warn_out_n) begin
			irq_cnt <= irq_cnt + 1;
		end
		// Releasing the pin is the crude way; the bench prefers a longer period
		float_q <= (mode == 2'd2);
		if (mode == 2'd2) begin
			kick_q <= 1'b1; // Pull-up holds a released pin high
		end else if (mode == 2'd1 && cnt >= gap) begin
			kick_q <= !kick_q;
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule : host_model
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the supervisor control logic.
// Assumes the design, the package and the host model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "sup_regs.svh"
module testbench;
	import sup_pkg::*;
	localparam int POR = 20;
	localparam int SHORT = 40;
	localparam int LONG = 160;
	logic clock = 1'b0;
	logic clk_en = 1'b1;
	logic sys_rst = 1'b1;
	afe_t afe = '0;
	reg_req_t bus = '0;
	logic timebase_select = 1'b1;
	logic timebase_input = 1'b1;
	logic chip_en_in_n = 1'b1;
	logic dog_kick_in, dog_kick_float, irq, reset_out_n, reset_out, low_line_out_n;
	logic dog_expired_out_n, power_warn_out_n, chip_en_out_n, on_battery_out;
	logic [7:0] rdata;
	logic [7:0] rd_val;
	logic [1:0] mode = 2'd0;
	logic [7:0] gap = 8'd10;
	logic rnd_on = 1'b0;
	logic bk_rnd = 1'b0;
	logic osc_on = 1'b0;
	int osc_edges = 0;
	int warn_irqs, e0, n;
	int num_errors = 0;
	int comparisons = 0;
	logic p_rst, p_en, p_bat, p_bat2, p_low, p_warn, p_ce;

	initial forever #25 clock = !clock;

	supervisor_core #(.POR_CYC(32'd20), .SHORT_CYC(32'd40), .LONG_CYC(32'd160)) i_supervisor_core (
		.clock(clock), .clk_en(clk_en), .sys_rst(sys_rst), .afe(afe),
		.dog_kick_in(dog_kick_in), .dog_kick_float(dog_kick_float),
		.timebase_select(timebase_select), .timebase_input(timebase_input),
		.chip_en_in_n(chip_en_in_n), .bus(bus), .rdata(rdata), .irq(irq),
		.reset_out_n(reset_out_n), .reset_out(reset_out), .low_line_out_n(low_line_out_n),
		.dog_expired_out_n(dog_expired_out_n), .power_warn_out_n(power_warn_out_n),
		.chip_en_out_n(chip_en_out_n), .on_battery_out(on_battery_out));

	host_model i_host_model (.clock(clock), .mode(mode), .gap(gap),
		.power_warn_out_n(power_warn_out_n), .dog_kick_in(dog_kick_in),
		.dog_kick_float(dog_kick_float), .warn_irqs(warn_irqs));

	task automatic check_bit(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask : check_bit

	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : check_byte

	task automatic check_span(input string what, input int lo, input int hi, input int got);
		comparisons++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : check_span

	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clock);
		bus.rd <= 1'b0;
		@(negedge clock);
		d = rdata;
	endtask : reg_read

	// Counts cycles until reset reaches level v; ends on a falling edge
	task automatic wait_rst(input logic v, input int lim, output int cnt);
		cnt = 0;
		while (reset_out_n !== v && cnt < lim) begin
			@(negedge clock);
			cnt++;
		end
	endtask : wait_rst

	// Blocking capture reads the inputs before this edge's stimulus lands
	always @(posedge clock) begin
		p_bat2 = p_bat;
		{p_rst, p_en, p_bat} = {sys_rst, clk_en, afe.on_battery};
		{p_low, p_warn, p_ce} = {afe.supply_low, afe.warn_low, chip_en_in_n};
		if (rnd_on) begin
			afe.warn_low <= 1'($urandom);
			chip_en_in_n <= 1'($urandom);
		end
		if (bk_rnd) begin
			timebase_select <= 1'($urandom);
			timebase_input <= 1'($urandom);
		end else if (osc_on) begin
			timebase_input <= !timebase_input;
			if (!timebase_input) begin
				osc_edges <= osc_edges + 1;
			end
		end
	end

	always @(negedge clock) begin
		if (p_rst === 1'b0 && p_en === 1'b1) begin
			check_bit("on_battery", p_bat, on_battery_out);
			check_bit("low_line", !(p_low || p_bat), low_line_out_n);
			check_bit("warn", !(p_warn || p_bat), power_warn_out_n);
			check_bit("chip_en", p_ce || p_low || p_bat, chip_en_out_n);
			check_bit("reset_hi", !reset_out_n, reset_out);
			if (p_bat && p_bat2) begin
				check_bit("reset_bk", 1'b0, reset_out_n);
				check_bit("dog_bk", 1'b1, dog_expired_out_n);
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		results();
	end

	initial begin
		void'($urandom(32'h56bc));
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		rnd_on <= 1'b1;
		afe.supply_low <= 1'b1;
		repeat (5) @(posedge clock);
		afe.supply_low <= 1'b0;
		wait_rst(1'b1, 1000, n);
		check_span("por", POR, POR + 5, n);
		$display("test power_on done");
		wait_rst(1'b0, 1000, n);
		check_span("first_long", LONG, LONG + 5, n);
		check_bit("dog_low", 1'b0, dog_expired_out_n);
		reg_read(`SUP_ADDR_STATUS, rd_val);
		check_bit("status_dog", 1'b1, rd_val[`SUP_EV_DOG]);
		wait_rst(1'b1, 1000, n);
		@(posedge clock);
		timebase_input <= 1'b0;
		mode <= 2'd1;
		repeat (100) @(posedge clock);
		@(negedge clock);
		check_bit("dog_kicked", 1'b1, dog_expired_out_n);
		check_bit("kept_alive", 1'b1, reset_out_n);
		@(posedge clock);
		mode <= 2'd0;
		wait_rst(1'b0, 1000, n);
		check_span("short", SHORT - 12, SHORT + 5, n);
		wait_rst(1'b1, 1000, n);
		wait_rst(1'b0, 1000, n);
		check_span("after_rst", LONG, LONG + 5, n);
		$display("test internal done");
		wait_rst(1'b1, 1000, n);
		@(posedge clock);
		mode <= 2'd2;
		wait_rst(1'b0, 400, n);
		check_span("float", 400, 400, n);
		$display("test float done");
		@(posedge clock);
		timebase_select <= 1'b0;
		osc_on <= 1'b1;
		repeat (20) @(posedge clock);
		mode <= 2'd1;
		repeat (30) @(posedge clock);
		mode <= 2'd0;
		@(negedge clock);
		e0 = osc_edges;
		wait_rst(1'b0, 6000, n);
		check_span("ext_period", 1016, 1027, osc_edges - e0);
		e0 = osc_edges;
		wait_rst(1'b1, 3000, n);
		check_span("ext_stretch", 510, 515, osc_edges - e0);
		$display("test external done");
		@(posedge clock);
		osc_on <= 1'b0;
		afe.on_battery <= 1'b1;
		bk_rnd <= 1'b1;
		mode <= 2'd1;
		gap <= 8'd2;
		repeat (200) @(posedge clock);
		bk_rnd <= 1'b0;
		@(posedge clock);
		afe.on_battery <= 1'b0;
		timebase_select <= 1'b1;
		repeat (5) @(posedge clock);
		$display("test backup done");
		@(negedge clock);
		check_bit("irq_masked", 1'b0, irq);
		reg_write(`SUP_ADDR_MASK, 8'h08);
		@(negedge clock);
		check_bit("irq_on", 1'b1, irq);
		reg_read(`SUP_ADDR_MASK, rd_val);
		check_byte("mask", 8'h08, rd_val);
		reg_write(`SUP_ADDR_STATUS, 8'h08);
		@(negedge clock);
		check_bit("irq_off", 1'b0, irq);
		reg_read(4'hc, rd_val);
		check_byte("unmapped", 8'h00, rd_val);
		check_span("warn_irqs", 1, 1000000, warn_irqs);
		$display("test registers done");
		@(posedge clock);
		clk_en <= 1'b0;
		afe.supply_low <= 1'b1;
		repeat (10) @(posedge clock);
		@(negedge clock);
		check_bit("frozen_low", 1'b1, low_line_out_n);
		@(posedge clock);
		clk_en <= 1'b1;
		repeat (3) @(posedge clock);
		@(negedge clock);
		check_bit("low_after", 1'b0, low_line_out_n);
		@(posedge clock);
		afe.supply_low <= 1'b0;
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		wait_rst(1'b1, 1000, n);
		check_span("por_again", POR, POR + 5, n);
		$display("test freeze done");
		results();
	end
endmodule : testbench
`default_nettype wire
